// ==== hdl/psw_gain_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface psw_gain_if;
  import psw_pkg::*;
  logic second_sel;
  logic ramping;
  logic [GAIN_W-1:0] gain;
  modport ctrl (output second_sel, input ramping, input gain);
  modport ramp (input second_sel, output ramping, output gain);
endinterface : psw_gain_if
`default_nettype wire

// ==== hdl/psw_hyst_cmp.sv ====
`timescale 1ns/10ps
`default_nettype none
module psw_hyst_cmp (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [psw_pkg::QTY_W-1:0] i_magnitude,
  input wire logic [psw_pkg::LEVEL_W-1:0] i_level,
  input wire logic [psw_pkg::LEVEL_W-1:0] i_hyst,
  output logic o_hit
);
  import psw_pkg::*;

  logic hit_ff;
  logic [LEVEL_W-1:0] hyst_eff;
  logic [LEVEL_W-1:0] release_lvl;

  assign hyst_eff = (i_level < i_hyst) ? i_level : i_hyst;
  assign release_lvl = i_level - hyst_eff;

  // Set at level, release below band
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hit_ff <= 1'b0;
    end else if (i_magnitude >= QTY_W'(i_level)) begin
      hit_ff <= 1'b1;
    end else if (i_magnitude < QTY_W'(release_lvl)) begin
      hit_ff <= 1'b0;
    end
  end

  assign o_hit = hit_ff;
endmodule : psw_hyst_cmp
`default_nettype wire

// ==== hdl/psw_pkg.sv ====
package psw_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STEP_TIME_PS = 100000000;
  localparam int STEP_CYCLES_DFLT = (STEP_TIME_PS + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;

  // ************************************************************
  // Field widths and ranges
  // ************************************************************
  localparam int MODE_W = 4;
  localparam int TIME_W = 14;
  localparam int LEVEL_W = 15;
  localparam int GAIN_W = 16;
  localparam int QTY_W = 16;
  localparam logic [MODE_W-1:0] MODE_MAX = 4'hA;
  localparam logic [TIME_W-1:0] TIME_MAX = 14'h2710;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 15'h4E20;

  // ************************************************************
  // Switching modes
  // ************************************************************
  localparam logic [MODE_W-1:0] MODE_FIRST = 4'h0;
  localparam logic [MODE_W-1:0] MODE_SECOND = 4'h1;
  localparam logic [MODE_W-1:0] MODE_TORQUE = 4'h3;
  localparam logic [MODE_W-1:0] MODE_VELOCITY = 4'h5;
  localparam logic [MODE_W-1:0] MODE_DEVIATION = 4'h6;
  localparam logic [MODE_W-1:0] MODE_CMD = 4'h7;
  localparam logic [MODE_W-1:0] MODE_NOT_INPOS = 4'h8;
  localparam logic [MODE_W-1:0] MODE_SPEED = 4'h9;
  localparam logic [MODE_W-1:0] MODE_CMD_SPEED = 4'hA;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_DELAY = 5'h04;
  localparam logic [ADDR_W-1:0] REG_LEVEL = 5'h08;
  localparam logic [ADDR_W-1:0] REG_HYST = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_RAMP = 5'h10;
  localparam logic [ADDR_W-1:0] REG_GAIN1 = 5'h14;
  localparam logic [ADDR_W-1:0] REG_GAIN2 = 5'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h1C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int STAT_SECOND_BIT = 0;
  localparam int STAT_RAMP_BIT = 1;
  localparam int STAT_TRIG_BIT = 2;
  localparam int STAT_GAIN_LSB = 16;
  localparam logic [GAIN_W-1:0] GAIN_RST = 16'h0000;

  typedef enum {
    PSW_ST_FIRST,
    PSW_ST_SECOND,
    PSW_ST_RETURN
  } psw_state_e;

endpackage : psw_pkg

// ==== hdl/psw_ramp.sv ====
`timescale 1ns/10ps
`default_nettype none
module psw_ramp (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [psw_pkg::GAIN_W-1:0] i_first_gain,
  input wire logic [psw_pkg::GAIN_W-1:0] i_second_gain,
  input wire logic [31:0] i_ramp_cycles,
  psw_gain_if.ramp gif
);
  import psw_pkg::*;

  logic [GAIN_W-1:0] gain_ff;
  logic [GAIN_W-1:0] diff_ff;
  logic [32:0] acc_ff;
  logic ramping_ff;
  logic [GAIN_W-1:0] target;
  logic [32:0] acc_sum;

  assign target = gif.second_sel ? i_second_gain : i_first_gain;
  assign acc_sum = acc_ff + 33'(diff_ff);

  // Gradual rise of gain
  // Spread over clocks; at most one step per clock, so a large
  // step in a very short time finishes late rather than overshoots
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gain_ff <= GAIN_RST;
      diff_ff <= '0;
      acc_ff <= '0;
      ramping_ff <= 1'b0;
    end else if (target <= gain_ff || i_ramp_cycles == 32'h0000_0000) begin
      gain_ff <= target;
      ramping_ff <= 1'b0;
      acc_ff <= '0;
    end else if (!ramping_ff) begin
      ramping_ff <= 1'b1;
      diff_ff <= target - gain_ff;
      acc_ff <= '0;
    end else if (acc_sum >= 33'(i_ramp_cycles)) begin
      gain_ff <= gain_ff + 16'h0001;
      acc_ff <= acc_sum - 33'(i_ramp_cycles);
    end else begin
      acc_ff <= acc_sum;
    end
  end

  assign gif.gain = gain_ff;
  assign gif.ramping = ramping_ff;
endmodule : psw_ramp
`default_nettype wire

// ==== hdl/psw_top.sv ====
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module psw_top #(
  parameter int P_STEP_CYCLES = psw_pkg::STEP_CYCLES_DFLT
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [psw_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [psw_pkg::QTY_W-1:0] i_torque_cmd,
  input wire logic [psw_pkg::QTY_W-1:0] i_velocity_cmd,
  input wire logic [psw_pkg::QTY_W-1:0] i_position_deviation,
  input wire logic [psw_pkg::QTY_W-1:0] i_actual_speed,
  input wire logic i_position_cmd_exists,
  input wire logic i_in_position,
  output logic [psw_pkg::GAIN_W-1:0] o_position_loop_gain,
  output logic o_second_gain_active
);
  import psw_pkg::*;

  // ************************************************************
  // Parameter checks
  // ************************************************************
  if (P_STEP_CYCLES < 1 || P_STEP_CYCLES > 200000) begin : g_bad_step
    $error("P_STEP_CYCLES out of range");
  end

  // ************************************************************
  // Register storage
  // ************************************************************
  logic second_gain_enable_ff;
  logic [MODE_W-1:0] position_switch_mode_ff;
  logic [TIME_W-1:0] position_switch_delay_ff;
  logic [LEVEL_W-1:0] position_switch_level_ff;
  logic [LEVEL_W-1:0] position_switch_hysteresis_ff;
  logic [TIME_W-1:0] position_gain_ramp_time_ff;
  logic [GAIN_W-1:0] first_position_loop_gain_ff;
  logic [GAIN_W-1:0] second_position_loop_gain_ff;
  logic ack_ff;
  logic [31:0] readdata_ff;
  logic wr_take;
  logic [31:0] old_word;
  logic [31:0] new_word;
  logic [31:0] rd_word;

  // ************************************************************
  // Trigger and state
  // ************************************************************
  psw_state_e state_ff;
  psw_state_e nxt_state;
  logic [31:0] step_cnt_ff;
  logic step_tick;
  logic [TIME_W-1:0] delay_cnt_ff;
  logic [QTY_W-1:0] lvl_magnitude;
  logic lvl_hit;
  logic trigger;
  logic fixed_mode;
  logic fixed_second;
  logic [31:0] ramp_cycles;

  psw_gain_if gif ();

  // ************************************************************
  // Avalon slave, one wait cycle per access
  // ************************************************************
  assign wr_take = i_avs_write && ack_ff;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (i_avs_read || i_avs_write) && !ack_ff;
    end
  end

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] wr_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wr_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  function automatic logic [TIME_W-1:0] clamp_time(input logic [31:0] v);
    logic [TIME_W-1:0] res;
    res = (v > 32'(TIME_MAX)) ? TIME_MAX : v[TIME_W-1:0];
    return res;
  endfunction : clamp_time

  function automatic logic [LEVEL_W-1:0] clamp_lvl(input logic [31:0] v);
    logic [LEVEL_W-1:0] res;
    res = (v > 32'(LEVEL_MAX)) ? LEVEL_MAX : v[LEVEL_W-1:0];
    return res;
  endfunction : clamp_lvl

  always_comb begin
    rd_word = 32'h0000_0000;
    case (i_avs_address)
      REG_CONTROL: begin
        rd_word[CTRL_EN_BIT] = second_gain_enable_ff;
        rd_word[CTRL_MODE_LSB +: MODE_W] = position_switch_mode_ff;
      end
      REG_DELAY: rd_word[TIME_W-1:0] = position_switch_delay_ff;
      REG_LEVEL: rd_word[LEVEL_W-1:0] = position_switch_level_ff;
      REG_HYST: rd_word[LEVEL_W-1:0] = position_switch_hysteresis_ff;
      REG_RAMP: rd_word[TIME_W-1:0] = position_gain_ramp_time_ff;
      REG_GAIN1: rd_word[GAIN_W-1:0] = first_position_loop_gain_ff;
      REG_GAIN2: rd_word[GAIN_W-1:0] = second_position_loop_gain_ff;
      REG_STATUS: begin
        rd_word[STAT_SECOND_BIT] = gif.second_sel;
        rd_word[STAT_RAMP_BIT] = gif.ramping;
        rd_word[STAT_TRIG_BIT] = trigger;
        rd_word[STAT_GAIN_LSB +: GAIN_W] = gif.gain;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign old_word = rd_word;
  assign new_word = merge_be(old_word, i_avs_writedata, i_avs_byteenable);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      readdata_ff <= 32'h0000_0000;
    end else if (i_avs_read && !ack_ff) begin
      readdata_ff <= rd_word;
    end
  end

  assign o_avs_readdata = readdata_ff;

  // Out-of-range writes clamp so the logic never sees them
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      second_gain_enable_ff <= 1'b0;
      position_switch_mode_ff <= MODE_FIRST;
    end else if (wr_take && i_avs_address == REG_CONTROL) begin
      second_gain_enable_ff <= new_word[CTRL_EN_BIT];
      position_switch_mode_ff <=
        (new_word[CTRL_MODE_LSB +: MODE_W] > MODE_MAX) ?
        MODE_MAX : new_word[CTRL_MODE_LSB +: MODE_W];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      position_switch_delay_ff <= '0;
      position_gain_ramp_time_ff <= '0;
    end else if (wr_take && i_avs_address == REG_DELAY) begin
      position_switch_delay_ff <= clamp_time(new_word);
    end else if (wr_take && i_avs_address == REG_RAMP) begin
      position_gain_ramp_time_ff <= clamp_time(new_word);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      position_switch_level_ff <= '0;
      position_switch_hysteresis_ff <= '0;
    end else if (wr_take && i_avs_address == REG_LEVEL) begin
      position_switch_level_ff <= clamp_lvl(new_word);
    end else if (wr_take && i_avs_address == REG_HYST) begin
      position_switch_hysteresis_ff <= clamp_lvl(new_word);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      first_position_loop_gain_ff <= GAIN_RST;
      second_position_loop_gain_ff <= GAIN_RST;
    end else if (wr_take && i_avs_address == REG_GAIN1) begin
      first_position_loop_gain_ff <= new_word[GAIN_W-1:0];
    end else if (wr_take && i_avs_address == REG_GAIN2) begin
      second_position_loop_gain_ff <= new_word[GAIN_W-1:0];
    end
  end

  // ************************************************************
  // Control step, 0.1 ms
  // ************************************************************
  assign step_tick = (step_cnt_ff == 32'(P_STEP_CYCLES - 1));

  always_ff @(posedge i_clk) begin
    if (i_reset || step_tick) begin
      step_cnt_ff <= 32'h0000_0000;
    end else begin
      step_cnt_ff <= step_cnt_ff + 32'h0000_0001;
    end
  end

  // ************************************************************
  // Trigger selection
  // ************************************************************
  // Quantity by mode
  always_comb begin
    case (position_switch_mode_ff)
      MODE_TORQUE: lvl_magnitude = i_torque_cmd;
      MODE_VELOCITY: lvl_magnitude = i_velocity_cmd;
      MODE_DEVIATION: lvl_magnitude = i_position_deviation;
      default: lvl_magnitude = i_actual_speed;
    endcase
  end

  psw_hyst_cmp u_cmp (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_magnitude(lvl_magnitude),
    .i_level(position_switch_level_ff),
    .i_hyst(position_switch_hysteresis_ff),
    .o_hit(lvl_hit)
  );

  always_comb begin
    trigger = 1'b0;
    fixed_mode = 1'b0;
    fixed_second = 1'b0;
    case (position_switch_mode_ff)
      MODE_SECOND: begin
        fixed_mode = 1'b1;
        fixed_second = 1'b1;
      end
      MODE_TORQUE, MODE_VELOCITY, MODE_DEVIATION, MODE_SPEED: begin
        trigger = lvl_hit;
      end
      MODE_CMD: trigger = i_position_cmd_exists;
      MODE_NOT_INPOS: trigger = !i_in_position;
      MODE_CMD_SPEED: trigger = i_position_cmd_exists || lvl_hit;
      default: fixed_mode = 1'b1;
    endcase
    if (!second_gain_enable_ff) begin
      trigger = 1'b0;
      fixed_mode = 1'b1;
      fixed_second = 1'b0;
    end
  end

  // ************************************************************
  // Gain set state machine
  // ************************************************************
  // Delayed return to first
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PSW_ST_FIRST: begin
        if (fixed_mode ? fixed_second : trigger) begin
          nxt_state = PSW_ST_SECOND;
        end
      end
      PSW_ST_SECOND: begin
        if (fixed_mode) begin
          nxt_state = fixed_second ? PSW_ST_SECOND : PSW_ST_FIRST;
        end else if (!trigger) begin
          nxt_state = (position_switch_delay_ff == '0) ?
                      PSW_ST_FIRST : PSW_ST_RETURN;
        end
      end
      PSW_ST_RETURN: begin
        if (fixed_mode) begin
          nxt_state = fixed_second ? PSW_ST_SECOND : PSW_ST_FIRST;
        end else if (trigger) begin
          nxt_state = PSW_ST_SECOND;
        end else if (delay_cnt_ff >= position_switch_delay_ff) begin
          nxt_state = PSW_ST_FIRST;
        end
      end
      default: nxt_state = PSW_ST_FIRST;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= PSW_ST_FIRST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Counts step ticks; the first partial step counts as a whole step
  always_ff @(posedge i_clk) begin
    if (i_reset || state_ff != PSW_ST_RETURN) begin
      delay_cnt_ff <= '0;
    end else if (step_tick && delay_cnt_ff != TIME_MAX) begin
      delay_cnt_ff <= delay_cnt_ff + 14'h0001;
    end
  end

  assign gif.second_sel = (state_ff != PSW_ST_FIRST);

  // ************************************************************
  // Gain output
  // ************************************************************
  assign ramp_cycles = 32'(position_gain_ramp_time_ff) * 32'(P_STEP_CYCLES);

  psw_ramp u_ramp (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_first_gain(first_position_loop_gain_ff),
    .i_second_gain(second_position_loop_gain_ff),
    .i_ramp_cycles(ramp_cycles),
    .gif(gif)
  );

  assign o_position_loop_gain = gif.gain;
  assign o_second_gain_active = gif.second_sel;

endmodule : psw_top
`default_nettype wire

// ==== verification/position_gain_switching_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module position_gain_switching_bench;
  import psw_pkg::*;
  // ************************************************************
  // Signals and scoreboard
  // ************************************************************
  localparam int P_STEP = 4;
  localparam logic [31:0] SM = 32'hFFFF_0003;
  typedef struct {logic [31:0] e, m; logic [4:0] a;} psw_note_s;
  psw_note_s notes[$];
  psw_note_s n;
  int n_fail = 0;
  int checks_done = 0;
  logic i_clk = 1'h0;
  logic i_reset = 1'h1;
  logic [4:0] i_avs_address;
  logic i_avs_read, i_avs_write;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [3:0] i_avs_byteenable;
  logic o_avs_waitrequest, i_position_cmd_exists, i_in_position, o_second;
  logic [15:0] i_torque_cmd, i_velocity_cmd, i_position_deviation;
  logic [15:0] i_actual_speed, o_gain, g1, g2;

  always #2.5 i_clk = ~i_clk;

  psw_top #(.P_STEP_CYCLES(P_STEP)) i_dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_torque_cmd(i_torque_cmd),
    .i_velocity_cmd(i_velocity_cmd),
    .i_position_deviation(i_position_deviation),
    .i_actual_speed(i_actual_speed),
    .i_position_cmd_exists(i_position_cmd_exists),
    .i_in_position(i_in_position), .o_position_loop_gain(o_gain),
    .o_second_gain_active(o_second));

  psw_host_model i_host (.i_clk(i_clk), .i_waitrequest(o_avs_waitrequest),
    .o_address(i_avs_address), .o_read(i_avs_read), .o_write(i_avs_write),
    .o_writedata(i_avs_writedata), .o_byteenable(i_avs_byteenable));

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // Judged at the accept edge, oldest note first
  always @(posedge i_clk) begin
    if (i_avs_read === 1'h1 && o_avs_waitrequest === 1'h0) begin
      n = notes.pop_front();
      check($sformatf("reg %h", n.a), o_avs_readdata & n.m, n.e & n.m);
      if (n.a == REG_STATUS) check("pins", {o_gain, 15'h0, o_second} & n.m,
          n.e & n.m & ~32'h2);
    end
  end

  task automatic wt(input int c);
    repeat (c) @(posedge i_clk);
  endtask : wt
  task automatic w(input logic [4:0] a, input logic [31:0] d);
    i_host.wr(a, d, 4'hF);
  endtask : w
  task automatic note(input logic [4:0] a, input logic [31:0] e, m);
    notes.push_back('{e, m, a});
    i_host.rd(a);
  endtask : note
  task automatic exst(input logic s);
    note(REG_STATUS, {s ? g2 : g1, 14'h0, 1'h0, s}, SM);
  endtask : exst
  task automatic ctl(input logic [3:0] m, input logic en);
    w(REG_CONTROL, {24'h0, m, 3'h0, en});
    wt(3);
  endtask : ctl
  task automatic put(input logic [15:0] t, v, d, s, input logic c, p);
    {i_torque_cmd, i_velocity_cmd, i_position_deviation} <= {t, v, d};
    i_actual_speed <= s;
    i_position_cmd_exists <= c;
    i_in_position <= p;
  endtask : put
  task automatic st(input logic c, p);
    put(16'h0, 16'h0, 16'h0, 16'h0, c, p);
  endtask : st

  task automatic lvl_case(input logic [3:0] m, input int idx);
    logic [15:0] q [4], v [4];
    logic e [4];
    v = '{16'h0063, 16'h0064, 16'h0050, 16'h004F};
    e = '{1'h0, 1'h1, 1'h1, 1'h0};
    st(1'h0, 1'h1);
    ctl(m, 1'h1);
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) q[j] = 16'($urandom_range(65535, 100));
      q[idx] = v[k];
      put(q[0], q[1], q[2], q[3], 1'h0, 1'h1);
      wt(4);
      exst(e[k]);
    end
  endtask : lvl_case

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    st(1'h0, 1'h1);
    void'($urandom(32'h9b75));
    wt(2);
    i_reset <= 1'h0;
    w(REG_STATUS, 32'hFFFF_FFFF);
    for (int a = 0; a < 32; a += 4) note(5'(a), 32'h0, 32'hFFFF_FFFF);
    note(5'h03, 32'h0, 32'hFFFF_FFFF);
    $display("test reset_map done");
    g1 = 16'h0100 | 16'($urandom_range(255, 0));
    g2 = 16'($urandom_range(255, 16));
    w(REG_DELAY, 32'h0000_FFFF);
    note(REG_DELAY, 32'h0000_2710, 32'hFFFF_FFFF);
    w(REG_LEVEL, 32'hFFFF_FFFF);
    note(REG_LEVEL, 32'h0000_4E20, 32'hFFFF_FFFF);
    w(REG_RAMP, 32'h0000_3FFF);
    note(REG_RAMP, 32'h0000_2710, 32'hFFFF_FFFF);
    w(REG_CONTROL, 32'h0000_00F0);
    note(REG_CONTROL, 32'h0000_00A0, 32'hFFFF_FFFF);
    i_host.wr(REG_GAIN1, {16'h0, g1}, 4'h1);
    note(REG_GAIN1, {24'h0, g1[7:0]}, 32'hFFFF_FFFF);
    w(REG_GAIN1, {16'h0, g1});
    w(REG_GAIN2, {16'h0, g2});
    w(REG_DELAY, 32'h0);
    w(REG_RAMP, 32'h0);
    $display("test fields done");
    foreach (g1[i]) if (i < 5 && i != 3) begin
      ctl(4'(i), 1'h1);
      exst(i == 1);
    end
    ctl(MODE_SECOND, 1'h0);
    exst(1'h0);
    $display("test fixed_modes done");
    st(1'h1, 1'h1);
    ctl(MODE_CMD, 1'h1);
    exst(1'h1);
    ctl(MODE_NOT_INPOS, 1'h1);
    exst(1'h0);
    st(1'h0, 1'h0);
    wt(3);
    exst(1'h1);
    ctl(MODE_CMD_SPEED, 1'h1);
    exst(1'h0);
    st(1'h1, 1'h1);
    wt(3);
    exst(1'h1);
    $display("test state_modes done");
    i_host.cfg_trig(32'd100, 32'd20);
    lvl_case(MODE_TORQUE, 0);
    lvl_case(MODE_VELOCITY, 1);
    lvl_case(MODE_DEVIATION, 2);
    lvl_case(MODE_SPEED, 3);
    lvl_case(MODE_CMD_SPEED, 3);
    $display("test level_modes done");
    w(REG_LEVEL, 32'd50);
    w(REG_HYST, 32'd200);
    put(16'h0, 16'h0, 16'h0, 16'd50, 1'h0, 1'h1);
    ctl(MODE_SPEED, 1'h1);
    st(1'h0, 1'h1);
    wt(4);
    exst(1'h1);
    $display("test hyst_clip done");
    w(REG_DELAY, 32'd3);
    ctl(MODE_CMD, 1'h1);
    for (int k = 0; k < 2; k++) begin
      st(1'h1, 1'h1);
      wt(3);
      st(1'h0, 1'h1);
      wt(2);
      exst(1'h1);
      st(k == 1, 1'h1);
      wt(20);
      exst(k == 1);
    end
    $display("test return_delay done");
    w(REG_DELAY, 32'h0);
    g2 = g1 - 16'h0004;
    w(REG_GAIN2, {16'h0, g2});
    ctl(MODE_SECOND, 1'h1);
    w(REG_RAMP, 32'd2);
    ctl(MODE_FIRST, 1'h1);
    note(REG_STATUS, 32'h0000_0002, 32'h0000_0003);
    wt(30);
    exst(1'h0);
    ctl(MODE_SECOND, 1'h1);
    exst(1'h1);
    $display("test gain_ramp done");
    wt(2);
    final_report();
  end

  // Run is a few hundred cycles; ample margin
  initial begin
    wt(40000);
    n_fail++;
    final_report();
  end
endmodule : position_gain_switching_bench
`default_nettype wire

// ==== verification/psw_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module psw_host_model
  import psw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_waitrequest,
  output logic [psw_pkg::ADDR_W-1:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  // ************************************************************
  // Avalon-MM master
  // ************************************************************
  initial begin
    o_address = 5'h00;
    o_read = 1'h0;
    o_write = 1'h0;
    o_writedata = 32'h0000_0000;
    o_byteenable = 4'h0;
  end

  // Released address and data lines show the inverse
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    @(posedge i_clk);
    o_address <= a;
    o_writedata <= d;
    o_byteenable <= be;
    o_write <= 1'h1;
    do @(posedge i_clk); while (i_waitrequest !== 1'h0);
    o_write <= 1'h0;
    o_address <= ~a;
    o_writedata <= ~d;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge i_clk);
    o_address <= a;
    o_read <= 1'h1;
    do @(posedge i_clk); while (i_waitrequest !== 1'h0);
    o_read <= 1'h0;
    o_address <= ~a;
  endtask : rd

  task automatic cfg_trig(input logic [31:0] l, h);
    if (h > l) h = l;
    wr(REG_LEVEL, l, 4'hF);
    wr(REG_HYST, h, 4'hF);
  endtask : cfg_trig
endmodule : psw_host_model
`default_nettype wire

// ==== verification/psw_top_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module psw_top_assertions
  import psw_pkg::*;
#(
  parameter int P_STEP_CYCLES = 4
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [psw_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [psw_pkg::QTY_W-1:0] i_torque_cmd,
  input wire logic [psw_pkg::QTY_W-1:0] i_velocity_cmd,
  input wire logic [psw_pkg::QTY_W-1:0] i_position_deviation,
  input wire logic [psw_pkg::QTY_W-1:0] i_actual_speed,
  input wire logic i_position_cmd_exists,
  input wire logic i_in_position,
  input wire logic [psw_pkg::GAIN_W-1:0] o_position_loop_gain,
  input wire logic o_second_gain_active
);
  // ************************************************************
  // Setup register shadow
  // ************************************************************
  logic en_ff;
  logic [MODE_W-1:0] mode_ff;
  logic [LEVEL_W-1:0] lvl_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] nxt_lvl;
  logic wr_ok;
  logic lvl_md;

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] b);
    for (int k = 0; k < 4; k++) begin
      if (b[k]) o[8*k+:8] = d[8*k+:8];
    end
    return o;
  endfunction : merge

  assign wr_ok = i_avs_write && !o_avs_waitrequest;
  assign nxt_ctrl = merge({24'h0, mode_ff, 3'h0, en_ff}, i_avs_writedata,
                          i_avs_byteenable);
  assign nxt_lvl = merge({17'h0, lvl_ff}, i_avs_writedata, i_avs_byteenable);
  assign lvl_md = en_ff && mode_ff == MODE_SPEED;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      en_ff <= 1'h0;
      mode_ff <= 4'h0;
    end else if (wr_ok && i_avs_address == REG_CONTROL) begin
      en_ff <= nxt_ctrl[0];
      mode_ff <= (nxt_ctrl[7:4] > MODE_MAX) ? MODE_MAX : nxt_ctrl[7:4];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lvl_ff <= 15'h0000;
    end else if (wr_ok && i_avs_address == REG_LEVEL) begin
      lvl_ff <= (nxt_lvl > {17'h0, LEVEL_MAX}) ? LEVEL_MAX : nxt_lvl[14:0];
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // ************************************************************
  // Properties
  // ************************************************************
  a_wait_one_cycle: assert property ($rose(i_avs_read || i_avs_write)
    |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("waitrequest not one cycle");
  a_idle_no_wait: assert property (!(i_avs_read || i_avs_write)
    |-> !o_avs_waitrequest) else $error("waitrequest high while idle");
  a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
    && (|i_avs_address[1:0]) |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_disable_first: assert property (!en_ff ##1 !en_ff |->
    !o_second_gain_active) else $error("second gain while disabled");
  a_fixed_second: assert property (en_ff && mode_ff == MODE_SECOND
    ##1 en_ff && mode_ff == MODE_SECOND |-> o_second_gain_active)
    else $error("mode one not on second gain");
  a_fixed_first: assert property ((en_ff && (mode_ff == 4'h0
    || mode_ff == 4'h2 || mode_ff == 4'h4)) [*2] |-> !o_second_gain_active)
    else $error("second gain in first mode");
  a_cmd_second: assert property (en_ff && mode_ff == MODE_CMD
    && i_position_cmd_exists |=> o_second_gain_active)
    else $error("command trigger missed");
  a_inpos_second: assert property (en_ff && mode_ff == MODE_NOT_INPOS
    && !i_in_position |=> o_second_gain_active)
    else $error("not in position trigger missed");
  a_level_second: assert property (lvl_md && i_actual_speed >= lvl_ff
    ##1 lvl_md && $stable(lvl_ff) |=> o_second_gain_active)
    else $error("level trigger missed");
endmodule : psw_top_assertions

bind psw_top psw_top_assertions #(.P_STEP_CYCLES(P_STEP_CYCLES)) i_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_torque_cmd(i_torque_cmd), .i_velocity_cmd(i_velocity_cmd),
  .i_position_deviation(i_position_deviation),
  .i_actual_speed(i_actual_speed),
  .i_position_cmd_exists(i_position_cmd_exists),
  .i_in_position(i_in_position),
  .o_position_loop_gain(o_position_loop_gain),
  .o_second_gain_active(o_second_gain_active));
`default_nettype wire
